// [verilog/sbd_map.svh]
// Purpose: offsets, field positions and reset values for the branch decoder
// Assumes: 32-bit instruction words, byte addressing
// Notes:   definitions only
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
// --------------------------------------------------------------
// instruction fields, first word
// --------------------------------------------------------------
`define SBD_CLASS_HI     31
`define SBD_CLASS_LO     30
`define SBD_CLASS_TC     2'h2
`define SBD_OPC_HI       29
`define SBD_OPC_LO       27
`define SBD_PHASE_MSG    26
`define SBD_PHASE_CD     25
`define SBD_PHASE_IO     24
`define SBD_REL_BIT      23
`define SBD_RSVD_BIT     22
`define SBD_CARRY_BIT    21
`define SBD_FLY_BIT      20
`define SBD_TF_BIT       19
`define SBD_CDATA_BIT    18
`define SBD_CPHASE_BIT   17
`define SBD_WAIT_BIT     16
`define SBD_MASK_HI      15
`define SBD_MASK_LO      8
`define SBD_DATA_HI      7
`define SBD_DATA_LO      0
// --------------------------------------------------------------
// addressing and reset values
// --------------------------------------------------------------
`define SBD_INSN_BYTES   32'h00000008
`define SBD_ADDR_RST     32'h00000000
`define SBD_REL_W        24
// --------------------------------------------------------------
// register port offsets (word aligned)
// --------------------------------------------------------------
`define SBD_REG_CTRL     8'h00
`define SBD_REG_STAT     8'h04
`define SBD_REG_RET      8'h08
`define SBD_REG_OPND     8'h0c
`define SBD_REG_FETCH    8'h10
`define SBD_REG_CARRY    8'h14
`endif

// [verilog/sbd_pkg.sv]
// Purpose: shared types of the branch decoder
// Assumes: used with sbd_map.svh
// Notes:   types only
package sbd_pkg;
   typedef enum logic [2:0] {
      SBD_OP_JUMP = 3'h0,
      SBD_OP_CALL = 3'h1,
      SBD_OP_RET  = 3'h2,
      SBD_OP_INT  = 3'h3
   } sbd_opc_t;
   typedef enum logic [1:0] {
      SBD_ST_IDLE,
      SBD_ST_WAIT,
      SBD_ST_HALT
   } sbd_state_t;
endpackage

// [verilog/sbd_cond_if.sv]
// Purpose: carries the condition inputs from the top to the evaluator
// Assumes: single clock domain
// Notes:   plain grouping of wires
`timescale 1ns/10ps
interface sbd_cond_if;
   logic [31:0] insn;
   logic [2:0]  phase_latched;
   logic [7:0]  first_byte;
   logic        atn;
   logic        carry;
   logic        target_mode;
   logic        take;
   logic        illegal;
   modport top  (output insn, phase_latched, first_byte, atn, carry, target_mode,
                 input take, illegal);
   modport eval (input insn, phase_latched, first_byte, atn, carry, target_mode,
                 output take, illegal);
endinterface

// [verilog/sbd_cond_eval.sv]
// Purpose: evaluates the branch condition of a transfer-control word
// Assumes: inputs already synchronised to clk_sys
// Notes:   purely combinational
`timescale 1ns/10ps
`include "sbd_map.svh"
module sbd_cond_eval (
   sbd_cond_if.eval c
);
   import sbd_pkg::*;
   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   wire       tf_bit   = c.insn[`SBD_TF_BIT];
   wire       cdata    = c.insn[`SBD_CDATA_BIT];
   wire       cphase   = c.insn[`SBD_CPHASE_BIT];
   wire       ctest    = c.insn[`SBD_CARRY_BIT];
   wire [7:0] mask     = c.insn[`SBD_MASK_HI:`SBD_MASK_LO];
   wire [7:0] dbyte    = c.insn[`SBD_DATA_HI:`SBD_DATA_LO];
   wire [2:0] want_ph  = {c.insn[`SBD_PHASE_MSG], c.insn[`SBD_PHASE_CD],
                          c.insn[`SBD_PHASE_IO]};
   wire [2:0] opc      = c.insn[`SBD_OPC_HI:`SBD_OPC_LO];
   // masked bits ignored in the data compare
   wire       data_eq  = ((dbyte ^ c.first_byte) & ~mask) == 8'h00;
   // target mode tests attention, initiator compares latched phase
   wire       ph_eq    = c.target_mode ? c.atn
                                       : (want_ph == c.phase_latched);
   // a disabled compare counts as a match so both must agree
   wire       all_eq   = (~cdata | data_eq) & (~cphase | ph_eq);
   // tf=0 needs every enabled compare false, so a split result never transfers
   wire       any_en   = cdata | cphase;
   wire       none_eq  = (~cdata | ~data_eq) & (~cphase | ~ph_eq);
   // carry test replaces the compares entirely
   wire       hit_t    = ctest ? c.carry : all_eq;
   wire       hit_f    = ctest ? ~c.carry : (any_en & none_eq);
   // no compare and tf=1 gives unconditional; tf=0 gives no-op
   assign c.take    = tf_bit ? hit_t : hit_f;
   // carry with data or phase compare, or undefined opcode
   assign c.illegal = (opc > 3'h3) | (ctest & (cdata | cphase));
endmodule

// [verilog/sbd_branch_top.sv]
// Purpose: transfer-control decode and execute for the script sequencer
// Assumes: fetch logic presents each two-word instruction with insn_valid
// Notes:   register port: addr, wdata, wr, rd, rdata one cycle later
`timescale 1ns/10ps
`include "sbd_map.svh"
module sbd_branch_top (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // instruction from fetch
   input  wire logic        insn_valid,
   input  wire logic [31:0] insn_word0,
   input  wire logic [31:0] insn_word1,
   input  wire logic [31:0] insn_addr,
   // select/reselect result for the i/o class
   input  wire logic        io_done,
   input  wire logic        io_failed,
   // scsi side (pins)
   input  wire logic [2:0]  phase_pins,
   input  wire logic        phase_valid_pin,
   input  wire logic        atn_pin,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_first,
   input  wire logic        rx_is_in,
   // alu carry events
   input  wire logic        alu_carry_we,
   input  wire logic        alu_carry_val,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // results
   output logic             fetch_valid,
   output logic [31:0]      fetch_addr,
   output logic             busy,
   output logic             host_irq,
   output logic             nonhalting_interrupt_flag,
   output logic             illegal_irq
);
   import sbd_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [13:0] sync1_ff;
   logic [13:0] sync2_ff;
   // first stage read only by the second stage
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_ff <= 14'h0000;
         sync2_ff <= 14'h0000;
      end else begin
         sync1_ff <= {phase_pins, phase_valid_pin, atn_pin, rx_byte, rx_first};
         sync2_ff <= sync1_ff;
      end
   end
   wire [2:0] s_phase  = sync2_ff[13:11];
   wire       s_pvalid = sync2_ff[10];
   wire       s_atn    = sync2_ff[9];
   wire [7:0] s_byte   = sync2_ff[8:1];
   wire       s_first  = sync2_ff[0];

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   sbd_state_t  state_ff;
   sbd_state_t  nxt_state;
   logic [2:0]  phase_ff;
   logic        phase_new_ff;
   logic [7:0]  fbyte_ff;
   logic        carry_ff;
   logic        tmode_ff;
   logic [31:0] ret_ff;
   logic [31:0] instruction_operand_reg_ff;
   logic [31:0] insn_ff;
   logic [31:0] iaddr_ff;
   logic        fvalid_ff;
   logic [31:0] faddr_ff;
   logic        irq_ff;
   logic        fly_ff;
   logic        ill_ff;
   logic [31:0] rdata_ff;
   logic        busy_ff;

   // ------------------------------------------------------------
   // condition evaluation
   // ------------------------------------------------------------
   sbd_cond_if cif ();
   assign cif.insn          = (state_ff == SBD_ST_WAIT) ? insn_ff : insn_word0;
   assign cif.phase_latched = phase_ff;
   assign cif.first_byte    = fbyte_ff;
   assign cif.atn           = s_atn;
   assign cif.carry         = carry_ff;
   assign cif.target_mode   = tmode_ff;
   sbd_cond_eval u_eval (
      .c (cif)
   );

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire        is_tc     = insn_word0[`SBD_CLASS_HI:`SBD_CLASS_LO] == `SBD_CLASS_TC;
   wire        new_tc    = insn_valid & is_tc & (state_ff == SBD_ST_IDLE);
   // wait only in initiator mode, until an unserviced phase change
   wire        want_wait = new_tc & insn_word0[`SBD_WAIT_BIT] & ~tmode_ff
                           & ~phase_new_ff;
   wire        wait_done = (state_ff == SBD_ST_WAIT) & phase_new_ff;
   wire        eval_now  = (new_tc & ~want_wait) | wait_done;
   wire [31:0] cur_w0    = (state_ff == SBD_ST_WAIT) ? insn_ff : insn_word0;
   wire [31:0] cur_w1    = (state_ff == SBD_ST_WAIT) ? instruction_operand_reg_ff
                                                     : insn_word1;
   wire [31:0] cur_addr  = (state_ff == SBD_ST_WAIT) ? iaddr_ff : insn_addr;
   wire [2:0]  opc       = cur_w0[`SBD_OPC_HI:`SBD_OPC_LO];
   wire        seq_en    = eval_now & ~cif.illegal;
   wire        taken     = seq_en & cif.take;
   wire [31:0] seq_addr  = cur_addr + `SBD_INSN_BYTES;
   // signed offset from the instruction pointer
   wire [31:0] rel_off   = {{(32-`SBD_REL_W){cur_w1[`SBD_REL_W-1]}},
                            cur_w1[`SBD_REL_W-1:0]};
   wire [31:0] tgt_addr  = cur_w0[`SBD_REL_BIT] ? (cur_addr + rel_off)
                                                : cur_w1;
   wire        do_call   = taken & (opc == SBD_OP_CALL);
   wire        do_int    = taken & (opc == SBD_OP_INT);
   wire        int_halt  = do_int & ~cur_w0[`SBD_FLY_BIT];
   wire        int_fly   = do_int & cur_w0[`SBD_FLY_BIT];

   // next fetch address; operand ignored for return and interrupt
   logic [31:0] br_addr;
   always_comb begin
      br_addr = seq_addr;
      if (taken) begin
         unique case (opc)
            SBD_OP_JUMP: br_addr = tgt_addr;
            SBD_OP_CALL: br_addr = tgt_addr;
            SBD_OP_RET:  br_addr = ret_ff;
            default:     br_addr = seq_addr;
         endcase
      end
   end
   // i/o class failure branches to the second word
   wire        io_fetch  = io_done & (state_ff == SBD_ST_IDLE);
   wire [31:0] io_addr   = io_failed ? insn_word1 : insn_addr + `SBD_INSN_BYTES;
   // register strobes, declared here since the state machine reads resume
   wire        ctrl_wr     = reg_wr & (reg_addr == `SBD_REG_CTRL);
   wire        ctrl_resume = ctrl_wr & reg_wdata[0];
   wire        stat_clr    = reg_wr & (reg_addr == `SBD_REG_STAT);

   // ------------------------------------------------------------
   // sequencer state machine
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SBD_ST_IDLE: if (want_wait) nxt_state = SBD_ST_WAIT;
                      else if (int_halt | (new_tc & cif.illegal)) nxt_state = SBD_ST_HALT;
         SBD_ST_WAIT: if (wait_done & (int_halt | cif.illegal)) nxt_state = SBD_ST_HALT;
                      else if (wait_done) nxt_state = SBD_ST_IDLE;
         SBD_ST_HALT: if (ctrl_resume) nxt_state = SBD_ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      unique case (reg_addr)
         `SBD_REG_CTRL:  rd_mux = {31'h00000000, tmode_ff};
         `SBD_REG_STAT:  rd_mux = {26'h0000000, phase_new_ff, state_ff == SBD_ST_HALT,
                                   ill_ff, fly_ff, irq_ff, carry_ff};
         `SBD_REG_RET:   rd_mux = ret_ff;
         `SBD_REG_OPND:  rd_mux = instruction_operand_reg_ff;
         `SBD_REG_FETCH: rd_mux = faddr_ff;
         `SBD_REG_CARRY: rd_mux = {31'h00000000, carry_ff};
         default:        rd_mux = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------
   // phase latch and first byte
   // ------------------------------------------------------------
   // compared byte: inbound phases for initiator, outbound for target
   wire byte_ok = s_first & (tmode_ff ? ~rx_is_in : rx_is_in);
   wire ph_chg  = s_pvalid & (s_phase != phase_ff);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff     <= 3'h0;
         phase_new_ff <= 1'b0;
         fbyte_ff     <= 8'h00;
      end else begin
         if (s_pvalid) phase_ff <= s_phase;
         // a new change wins over the service clear
         phase_new_ff <= ph_chg | (phase_new_ff & ~eval_now);
         if (byte_ok) fbyte_ff <= s_byte;
      end
   end

   // ------------------------------------------------------------
   // carry, mode and return address
   // ------------------------------------------------------------
   // only the alu's add/set/clear events move the carry
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         carry_ff <= 1'b0;
         tmode_ff <= 1'b0;
         ret_ff   <= `SBD_ADDR_RST;
      end else begin
         if (alu_carry_we) carry_ff <= alu_carry_val;
         if (ctrl_wr) tmode_ff <= reg_wdata[1];
         if (do_call) ret_ff <= seq_addr;
      end
   end

   // ------------------------------------------------------------
   // instruction hold and results
   // ------------------------------------------------------------
   // operand word is loaded for every transfer-control word taken in the idle state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         insn_ff                    <= 32'h00000000;
         instruction_operand_reg_ff <= 32'h00000000;
         iaddr_ff                   <= `SBD_ADDR_RST;
         state_ff                   <= SBD_ST_IDLE;
         busy_ff                    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // busy taken from a flop so the output carries no decode
         busy_ff  <= nxt_state != SBD_ST_IDLE;
         if (new_tc) begin
            insn_ff                    <= insn_word0;
            instruction_operand_reg_ff <= insn_word1;
            iaddr_ff                   <= insn_addr;
         end
      end
   end

   // outputs registered; a clear loses to a same-cycle set
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fvalid_ff <= 1'b0;
         faddr_ff  <= `SBD_ADDR_RST;
         irq_ff    <= 1'b0;
         fly_ff    <= 1'b0;
         ill_ff    <= 1'b0;
         rdata_ff  <= 32'h00000000;
      end else begin
         fvalid_ff <= (seq_en & ~int_halt) | io_fetch;
         if (seq_en & ~int_halt) faddr_ff <= br_addr;
         else if (io_fetch) faddr_ff <= io_addr;
         irq_ff   <= int_halt | (irq_ff & ~(stat_clr & reg_wdata[1]));
         fly_ff   <= int_fly | (fly_ff & ~(stat_clr & reg_wdata[2]));
         ill_ff   <= (eval_now & cif.illegal)
                     | (ill_ff & ~(stat_clr & reg_wdata[3]));
         rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   assign reg_rdata                 = rdata_ff;
   assign fetch_valid               = fvalid_ff;
   assign fetch_addr                = faddr_ff;
   assign busy                      = busy_ff;
   assign host_irq                  = irq_ff;
   assign nonhalting_interrupt_flag = fly_ff;
   assign illegal_irq               = ill_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence call_taken_s;
      do_call;
   endsequence
   sequence ret_loaded_s;
      ##1 ret_ff == $past(seq_addr);
   endsequence
   call_saves_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      call_taken_s |-> ret_loaded_s) else $error("call did not save return address");
   seq_plus8_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (seq_en & ~taken) |=> fetch_addr == $past(cur_addr) + 32'h00000008)
      else $error("sequential address not plus eight");
   halt_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      int_halt |=> host_irq && busy) else $error("halting interrupt missing");
   fly_run_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      int_fly |=> nonhalting_interrupt_flag && fetch_valid && !busy)
      else $error("non-halting interrupt stalled");
   illegal_op_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (eval_now & (opc > 3'h3)) |=> illegal_irq && !fetch_valid)
      else $error("undefined opcode not flagged");
   carry_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !alu_carry_we |=> $stable(carry_ff)) else $error("carry changed unexpectedly");
   ret_target_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (taken & (opc == SBD_OP_RET)) |=> fetch_addr == $past(ret_ff))
      else $error("return went to wrong address");
   wait_phase_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_ff == SBD_ST_WAIT && !phase_new_ff) |=> !fetch_valid)
      else $error("wait released without phase change");
   io_fail_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (io_fetch & io_failed) |=> fetch_valid && fetch_addr == $past(insn_word1))
      else $error("failed select not redirected");
   carry_illegal_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (eval_now & cur_w0[`SBD_CARRY_BIT] & (cur_w0[`SBD_CDATA_BIT] | cur_w0[`SBD_CPHASE_BIT]))
      |=> illegal_irq && busy) else $error("carry test with compare not illegal");
   class_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (insn_valid & ~is_tc & ~io_done & (state_ff == SBD_ST_IDLE)) |=> !fetch_valid)
      else $error("non transfer-control word acted on");
   wait_enter_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      want_wait |=> busy) else $error("wait bit did not pause");
   resume_run_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((state_ff == SBD_ST_HALT) & ctrl_resume) |=> !busy) else $error("resume did not restart");
   byte_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      byte_ok |=> fbyte_ff == $past(s_byte)) else $error("compared byte not captured");
   rel_jump_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (taken & cur_w0[`SBD_REL_BIT] & (opc == SBD_OP_JUMP))
      |=> fetch_addr == $past(cur_addr + rel_off)) else $error("relative jump target wrong");
   phase_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_pvalid |=> phase_ff == $past(s_phase)) else $error("phase not latched");
endmodule

// [verif/sbd_bus_model.sv]
// Purpose: far-side bus model: phase lines, attention, received bytes
// Assumes: one clk_sys domain, tasks called just after a rising edge
// Notes:   released lines show the inverse of their last value
`timescale 1ns/10ps
module sbd_bus_model (
   clk_sys,
   phase_pins,
   phase_valid_pin,
   atn_pin,
   rx_byte,
   rx_first,
   rx_is_in
);
   input  wire logic  clk_sys;
   output logic [2:0] phase_pins;
   output logic       phase_valid_pin;
   output logic       atn_pin;
   output logic [7:0] rx_byte;
   output logic       rx_first;
   output logic       rx_is_in;
   // ---------------------------------------------
   // idle lines
   // ---------------------------------------------
   initial begin
      phase_pins = 3'h0;
      phase_valid_pin = 1'b0;
      atn_pin = 1'b0;
      rx_byte = 8'h00;
      rx_first = 1'b0;
      rx_is_in = 1'b0;
   end
   // valid only 3 cycles, then lines drift: only a latched copy survives
   task automatic set_phase(input logic [2:0] ph);
      phase_pins <= ph;
      phase_valid_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      phase_valid_pin <= 1'b0;
      phase_pins <= ~ph;
   endtask
   // first byte of an inbound transfer, strobe held 3 cycles
   task automatic send_byte(input logic [7:0] b);
      rx_is_in <= 1'b1;
      rx_byte <= b;
      rx_first <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rx_first <= 1'b0;
      rx_byte <= ~b;
   endtask
   task automatic set_atn(input logic v);
      atn_pin <= v;
   endtask
endmodule

// [verif/tb_top.sv]
// Purpose: self-checking bench for the transfer-control decoder
// Assumes: initiator mode unless switched, instruction address 0x100
// Notes:   table rows first, then halting and awkward cases
`timescale 1ns/10ps
`include "sbd_map.svh"
module tb_top;
   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] a;
      logic [31:0] e;
   } sbd_row_t;
   logic        clk_sys = 1'b0, reset_n = 1'b0, insn_valid = 1'b0, io_done = 1'b0;
   logic        io_failed = 1'b0, alu_carry_we = 1'b0, alu_carry_val = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00, rx_byte;
   logic [31:0] insn_word0 = 32'h0, insn_word1 = 32'h0, insn_addr = 32'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, fetch_addr;
   logic [2:0]  phase_pins;
   logic        phase_valid_pin, atn_pin, rx_first, rx_is_in, fetch_valid, busy;
   logic        host_irq, nonhalting_interrupt_flag, illegal_irq;
   int          num_errors = 0, total_checks = 0;
   // software keeps bit 22 clear in every row
   sbd_row_t    rows [21] = '{
      '{32'h80080000, 32'h2000, 32'h100, 32'h2000},
      '{32'h80000000, 32'h2000, 32'h100, 32'h108},
      '{32'h860a0000, 32'h2000, 32'h100, 32'h2000},
      '{32'h850a0000, 32'h2000, 32'h100, 32'h108},
      '{32'h85020000, 32'h2000, 32'h100, 32'h2000},
      '{32'h800c005a, 32'h2000, 32'h100, 32'h2000},
      '{32'h800c015b, 32'h2000, 32'h100, 32'h2000},
      '{32'h800c005b, 32'h2000, 32'h100, 32'h108},
      '{32'h860e005a, 32'h2000, 32'h100, 32'h2000},
      '{32'h860e005b, 32'h2000, 32'h100, 32'h108},
      '{32'h8506005b, 32'h2000, 32'h100, 32'h2000},
      '{32'h8606005b, 32'h2000, 32'h100, 32'h108},
      '{32'h80880000, 32'habfffff0, 32'h100, 32'hf0},
      '{32'h80280000, 32'h2000, 32'h100, 32'h2000},
      '{32'h80200000, 32'h2000, 32'h100, 32'h108},
      '{32'h88080000, 32'h3000, 32'h200, 32'h3000},
      '{32'h90080000, 32'h2000, 32'h600, 32'h208},
      '{32'h88080000, 32'h3000, 32'h100, 32'h3000},
      '{32'h88080000, 32'h3500, 32'h400, 32'h3500},
      '{32'h90080000, 32'h2000, 32'h700, 32'h408},
      '{32'h90000000, 32'h2000, 32'h700, 32'h708}};
   always #2 clk_sys = ~clk_sys;
   sbd_bus_model sbd_bus_model_i (.clk_sys(clk_sys), .phase_pins(phase_pins),
      .phase_valid_pin(phase_valid_pin), .atn_pin(atn_pin), .rx_byte(rx_byte),
      .rx_first(rx_first), .rx_is_in(rx_is_in));
   sbd_branch_top sbd_branch_top_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .insn_valid(insn_valid), .insn_word0(insn_word0), .insn_word1(insn_word1),
      .insn_addr(insn_addr), .io_done(io_done), .io_failed(io_failed),
      .phase_pins(phase_pins), .phase_valid_pin(phase_valid_pin), .atn_pin(atn_pin),
      .rx_byte(rx_byte), .rx_first(rx_first), .rx_is_in(rx_is_in),
      .alu_carry_we(alu_carry_we), .alu_carry_val(alu_carry_val), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .busy(busy),
      .host_irq(host_irq), .nonhalting_interrupt_flag(nonhalting_interrupt_flag),
      .illegal_irq(illegal_irq));
   // ---------------------------------------------
   // compare, bus and closing tasks
   // ---------------------------------------------
   task automatic end_of_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // bounded wait: a lost pulse must not hang the run
   task automatic wait_fetch();
      int n;
      n = 0;
      #1;
      while (fetch_valid !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 20) begin
         num_errors++;
         end_of_test();
      end
   endtask
   task automatic issue(input sbd_row_t r);
      @(posedge clk_sys);
      insn_word0 <= r.w0;
      insn_word1 <= r.w1;
      insn_addr <= r.a;
      insn_valid <= 1'b1;
      @(posedge clk_sys);
      insn_valid <= 1'b0;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk32(reg_rdata, e);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1 chk1(busy | host_irq | illegal_irq | fetch_valid, 1'b0);
      @(posedge clk_sys);
      alu_carry_we <= 1'b1;
      alu_carry_val <= 1'b1;
      @(posedge clk_sys);
      alu_carry_we <= 1'b0;
      sbd_bus_model_i.set_phase(3'h6);
      sbd_bus_model_i.send_byte(8'h5a);
      repeat (4) @(posedge clk_sys);
      foreach (rows[i]) begin
         issue(rows[i]);
         wait_fetch();
         chk32(fetch_addr, rows[i].e);
      end
      // a word of another class must neither fetch nor touch the return address
      issue('{32'h48080000, 32'h3000, 32'h100, 32'h0});
      #1 chk1(fetch_valid | busy, 1'b0);
      rd_chk(`SBD_REG_RET, 32'h408);
      rd_chk(`SBD_REG_CARRY, 32'h1);
      // wait bit: nothing may fetch until a fresh phase change
      issue('{32'h80090000, 32'h4000, 32'h100, 32'h0});
      repeat (6) begin
         #1 chk1(fetch_valid, 1'b0);
         @(posedge clk_sys);
      end
      fork
         sbd_bus_model_i.set_phase(3'h2);
         wait_fetch();
      join
      chk32(fetch_addr, 32'h4000);
      issue('{32'h98180000, 32'h2000, 32'h100, 32'h0});
      wait_fetch();
      chk32(fetch_addr, 32'h108);
      chk1(nonhalting_interrupt_flag & ~host_irq, 1'b1);
      reg_write(`SBD_REG_STAT, 32'h4);
      issue('{32'h98080000, 32'hc0de0011, 32'h100, 32'h0});
      repeat (2) @(posedge clk_sys);
      #1 chk1(host_irq & busy & ~fetch_valid, 1'b1);
      rd_chk(`SBD_REG_OPND, 32'hc0de0011);
      reg_write(`SBD_REG_CTRL, 32'h1);
      reg_write(`SBD_REG_STAT, 32'h2);
      #1 chk1(host_irq | busy, 1'b0);
      for (int k = 0; k < 2; k++) begin
         issue('{k ? 32'h802a0000 : 32'ha0080000, 32'h2000, 32'h100, 32'h0});
         repeat (2) @(posedge clk_sys);
         #1 chk1(illegal_irq & busy, 1'b1);
         reg_write(`SBD_REG_CTRL, 32'h1);
         reg_write(`SBD_REG_STAT, 32'h8);
      end
      for (int f = 0; f < 2; f++) begin
         @(posedge clk_sys);
         insn_word1 <= 32'h5000;
         insn_addr <= 32'h300;
         io_done <= 1'b1;
         io_failed <= f[0];
         @(posedge clk_sys);
         io_done <= 1'b0;
         wait_fetch();
         chk32(fetch_addr, f[0] ? 32'h5000 : 32'h308);
      end
      // mid-run reset drops a pending halt and the saved return address
      issue('{32'h98080000, 32'h0, 32'h100, 32'h0});
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1 chk1(busy | host_irq | illegal_irq | fetch_valid, 1'b0);
      rd_chk(`SBD_REG_RET, `SBD_ADDR_RST);
      // target mode: the phase-compare bit now tests attention
      reg_write(`SBD_REG_CTRL, 32'h2);
      for (int v = 1; v >= 0; v--) begin
         sbd_bus_model_i.set_atn(v[0]);
         repeat (4) @(posedge clk_sys);
         issue('{32'h800a0000, 32'h6000, 32'h100, 32'h0});
         wait_fetch();
         chk32(fetch_addr, v[0] ? 32'h6000 : 32'h108);
      end
      rd_chk(8'hfc, 32'h0);
      end_of_test();
   end
endmodule
